// ==== logic/gpp_port.sv ====
// Notes on behaviour
// [RL1] Analog high-Z default: no drive, no input
// [RL2] Digital high-Z: driver off, input sampled
// [RL3] Resistive pull: one state resistive, other strong
// [RL4] No resistive pull on regulated special pins
// [RL5] Open drain: one state floats, other strong
// [RL6] Strong mode drives both states strongly
// [RL7] Combined resistive: always through resistor
// [RL8] Port-wide form: bit n is pin n
// [RL9] Per-pin form aliases the same state
// [RL10] Bidir: aux enable selects input or drive
// [RL11] Up to 16 aux enables, routable per pin
// [RL12] Per-pin slew only for strong/open drain
// [RL13] Eight pins feed one port interrupt
// [RL14] Per-pin rising, falling, both, or off
// [RL15] Event sets status bit and raises request
// [RL16] Detection runs during sleep
// [RL17] Port-level CMOS or LVTTL threshold
// [RL18] Input buffer disable per pin, any mode
// [RL19] Special pins paired, shared 4-way threshold
// [RL20] Software keeps tolerant special pins in 0,1,4
// [RL21] Reset holds analog high-Z, loads stored defaults
// [RL22] Low power keeps pin state
// [RL23] Three-bit drive mode, codes 0 to 7
// [RL24] Separate pin-state read and data write
// [RL25] Inputs synchronised; status clears on read
// [RL26] Request drops when all status clear
`default_nettype none
module gpp_port
   import gpp_pkg::*;
#(
   parameter int NPINS = PINS
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic [NPINS-1:0] pinIn,
   output logic [NPINS-1:0] pinOut,
   output logic [NPINS-1:0] pinOe,
   output logic [NPINS-1:0] pinPullUp,
   output logic [NPINS-1:0] pinPullDown,
   output logic [NPINS-1:0] pinSlowSlew,
   output logic [NPINS-1:0] pinInBufEn,
   output logic lvttlSelect,
   output logic [1:0] pairThreshold0,
   output logic [1:0] pairThreshold1,
   output logic [1:0] pairThreshold2,
   output logic [1:0] pairThreshold3,
   input wire logic [NPINS-1:0] specialPin,
   input wire logic [NPINS-1:0] regulatedOut,
   input wire logic [NPINS*DM_W-1:0] resetDmDefault,
   input wire logic [NPINS-1:0] resetDataDefault,
   input wire logic portWrData,
   input wire logic [NPINS-1:0] dataIn,
   input wire logic portWrDm,
   input wire logic [NPINS*DM_W-1:0] dmIn,
   input wire logic portWrSlew,
   input wire logic [NPINS-1:0] slewIn,
   input wire logic portWrIbufDis,
   input wire logic [NPINS-1:0] ibufDisIn,
   input wire logic portWrBidir,
   input wire logic [NPINS-1:0] bidirIn,
   input wire logic portWrIrqType,
   input wire logic [NPINS*2-1:0] irqTypeIn,
   input wire logic portWrCfg,
   input wire logic lvttlIn,
   input wire logic [7:0] pairThresholdIn,
   input wire logic [NPINS*OE_SEL_W-1:0] oeSelIn,
   input wire logic pinWr,
   input wire logic [2:0] pinWrSel,
   input wire logic [PF_W-1:0] pinWrWord,
   input wire logic [2:0] pinRdSel,
   output logic [PF_W-1:0] pinRdWord,
   input wire logic [OE_LINES-1:0] auxOe,
   output logic [NPINS-1:0] pinStateRead,
   output logic [NPINS-1:0] outputDataWrite,
   input wire logic statusRead,
   output logic [NPINS-1:0] irqStatus,
   output logic portIrq
);
   if (NPINS != PINS) $error("gpp_port serves exactly eight pins");

   // ***********************************************
   // Configuration state
   // ***********************************************
   logic [NPINS-1:0] dataReg;
   logic [NPINS*DM_W-1:0] dmReg;
   logic [NPINS-1:0] slowReg;
   logic [NPINS-1:0] ibufDisReg;
   logic [NPINS-1:0] bidirReg;
   logic [NPINS*2-1:0] irqTypeReg;
   logic [NPINS*OE_SEL_W-1:0] oeSelReg;
   logic loadDefaults;
   logic inReset;

   // Reset forces analog high-Z; stored defaults land two edges after release
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         inReset <= 1'b1;
         loadDefaults <= 1'b0;
      end else begin
         inReset <= 1'b0;
         loadDefaults <= inReset; // RL21
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dataReg <= ZERO_BYTE;
         dmReg <= ZERO_DM; // RL1
         slowReg <= ZERO_BYTE;
         ibufDisReg <= ZERO_BYTE;
         bidirReg <= ZERO_BYTE;
         irqTypeReg <= ZERO_TYPE;
         oeSelReg <= '0;
         lvttlSelect <= 1'b0;
         pairThreshold0 <= 2'h0;
         pairThreshold1 <= 2'h0;
         pairThreshold2 <= 2'h0;
         pairThreshold3 <= 2'h0;
      end else if (loadDefaults) begin
         dmReg <= resetDmDefault; // RL21
         dataReg <= resetDataDefault;
      end else begin
         // Port form first, pin form last so a pin write wins on collision
         if (portWrData) dataReg <= dataIn; // RL8
         if (portWrDm) dmReg <= dmIn; // RL23
         if (portWrSlew) slowReg <= slewIn;
         if (portWrIbufDis) ibufDisReg <= ibufDisIn;
         if (portWrBidir) bidirReg <= bidirIn;
         if (portWrIrqType) irqTypeReg <= irqTypeIn;
         if (portWrCfg) begin
            lvttlSelect <= lvttlIn; // RL17
            pairThreshold0 <= pairThresholdIn[1:0]; // RL19
            pairThreshold1 <= pairThresholdIn[3:2];
            pairThreshold2 <= pairThresholdIn[5:4];
            pairThreshold3 <= pairThresholdIn[7:6];
            oeSelReg <= oeSelIn; // RL11
         end
         if (pinWr) begin
            dataReg[pinWrSel] <= pinWrWord[PF_DATA]; // RL9
            dmReg[pinWrSel*DM_W +: DM_W] <= pinWrWord[PF_DM_LSB +: DM_W];
            ibufDisReg[pinWrSel] <= pinWrWord[PF_IBUF_DIS];
            slowReg[pinWrSel] <= pinWrWord[PF_SLOW];
            bidirReg[pinWrSel] <= pinWrWord[PF_BIDIR];
         end
      end
   end

   // ***********************************************
   // Input synchroniser
   // ***********************************************
   logic [NPINS-1:0] syncA, syncB, syncC, pinFilt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         syncA <= ZERO_BYTE;
         syncB <= ZERO_BYTE;
         syncC <= ZERO_BYTE;
         pinFilt <= ZERO_BYTE;
      end else begin
         syncA <= pinIn; // RL25
         syncB <= syncA;
         syncC <= syncB;
         // Change counts only once the two later stages agree
         pinFilt <= (syncB == syncC) ? syncC : pinFilt;
      end
   end

   // ***********************************************
   // Per-pin drive decode
   // ***********************************************
   logic [NPINS-1:0] next_oe, next_out, next_pu, next_pd, next_ibuf, next_slow;
   logic [NPINS-1:0] bidirOeBit;
   genvar gi;
   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_pin
         gpp_drive_mode_t dm;
         logic d;
         assign bidirOeBit[gi] = auxOe[oeSelReg[gi*OE_SEL_W +: $clog2(OE_LINES)]];
         always_comb begin
            dm = gpp_drive_mode_t'(dmReg[gi*DM_W +: DM_W]);
            d = dataReg[gi];
            // Bidir with aux enable low falls back to digital input
            if (bidirReg[gi] && !bidirOeBit[gi]) dm = DM_DIGITAL_HIZ; // RL10
            // Regulated special pins lose resistive pulls, fall to input
            if (specialPin[gi] && regulatedOut[gi] &&
                (dm == DM_RES_PULL_UP || dm == DM_RES_PULL_DOWN ||
                 dm == DM_RES_PULL_BOTH)) dm = DM_DIGITAL_HIZ; // RL4
            next_out[gi] = d;
            next_oe[gi] = 1'b0;
            next_pu[gi] = 1'b0;
            next_pd[gi] = 1'b0;
            case (dm)
               DM_ANALOG_HIZ: next_out[gi] = 1'b0; // RL1
               DM_DIGITAL_HIZ: next_oe[gi] = 1'b0; // RL2
               DM_RES_PULL_UP: begin
                  next_oe[gi] = !d; // RL3
                  next_pu[gi] = d;
               end
               DM_RES_PULL_DOWN: begin
                  next_oe[gi] = d; // RL3
                  next_pd[gi] = !d;
               end
               DM_OPEN_DRAIN_LOW: next_oe[gi] = !d; // RL5
               DM_OPEN_DRAIN_HIGH: next_oe[gi] = d; // RL5
               DM_STRONG: next_oe[gi] = 1'b1; // RL6
               DM_RES_PULL_BOTH: begin
                  next_pu[gi] = d; // RL7
                  next_pd[gi] = !d;
               end
               default: next_oe[gi] = 1'b0;
            endcase
            next_ibuf[gi] = (dm != DM_ANALOG_HIZ) && !ibufDisReg[gi]; // RL18
            next_slow[gi] = slowReg[gi] && (dm == DM_OPEN_DRAIN_LOW ||
               dm == DM_OPEN_DRAIN_HIGH || dm == DM_STRONG); // RL12
         end
      end
   endgenerate

   // State is held across low power; nothing here depends on sleep
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pinOut <= ZERO_BYTE;
         pinOe <= ZERO_BYTE;
         pinPullUp <= ZERO_BYTE;
         pinPullDown <= ZERO_BYTE;
         pinSlowSlew <= ZERO_BYTE;
         pinInBufEn <= ZERO_BYTE; // RL1
      end else begin
         pinOut <= next_out; // RL22
         pinOe <= next_oe;
         pinPullUp <= next_pu;
         pinPullDown <= next_pd;
         pinSlowSlew <= next_slow;
         pinInBufEn <= next_ibuf;
      end
   end

   // ***********************************************
   // Read paths
   // ***********************************************
   logic [PF_W-1:0] next_pinRd;
   always_comb begin
      next_pinRd = '0;
      next_pinRd[PF_DATA] = dataReg[pinRdSel];
      next_pinRd[PF_DM_LSB +: DM_W] = dmReg[pinRdSel*DM_W +: DM_W];
      next_pinRd[PF_IBUF_DIS] = ibufDisReg[pinRdSel];
      next_pinRd[PF_SLOW] = slowReg[pinRdSel];
      next_pinRd[PF_BIDIR] = bidirReg[pinRdSel];
      next_pinRd[PF_STATE] = pinStateRead[pinRdSel];
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pinStateRead <= ZERO_BYTE;
         outputDataWrite <= ZERO_BYTE;
         pinRdWord <= '0;
      end else begin
         // Disabled buffers read zero, never the written data
         pinStateRead <= pinFilt & next_ibuf; // RL24
         outputDataWrite <= dataReg;
         pinRdWord <= next_pinRd; // RL9
      end
   end

   // ***********************************************
   // Port interrupt unit
   // ***********************************************
   logic [NPINS-1:0] prevIn, evt;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) prevIn <= ZERO_BYTE;
      else prevIn <= pinFilt;
   end

   generate
      for (gi = 0; gi < NPINS; gi++) begin : g_evt
         gpp_irq_type_t t;
         always_comb begin
            t = gpp_irq_type_t'(irqTypeReg[gi*2 +: 2]);
            case (t) // RL14
               IRQ_RISE: evt[gi] = pinFilt[gi] && !prevIn[gi];
               IRQ_FALL: evt[gi] = !pinFilt[gi] && prevIn[gi];
               IRQ_BOTH: evt[gi] = pinFilt[gi] ^ prevIn[gi];
               default: evt[gi] = 1'b0;
            endcase
         end
      end
   endgenerate

   // Clock assumed running in sleep so wake events are seen
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         irqStatus <= ZERO_BYTE;
         portIrq <= 1'b0;
      end else begin
         // New event beats the read-clear in the same cycle
         irqStatus <= (statusRead ? ZERO_BYTE : irqStatus) | evt; // RL15 RL25 RL16
         portIrq <= ((statusRead ? ZERO_BYTE : irqStatus) | evt) != ZERO_BYTE; // RL13 RL26
      end
   end

   // ***********************************************
   // Checks
   // ***********************************************
   property p_strong_drives;
      @(posedge clock) disable iff (!rst_n)
         (dmReg[2:0] == DM_STRONG && !bidirReg[0] && !loadDefaults) |=> pinOe[0];
   endproperty
   a_strong_drives: assert property (p_strong_drives) else $error("strong not driven"); // RL6

   property p_analog_quiet;
      @(posedge clock) disable iff (!rst_n)
         (dmReg[2:0] == DM_ANALOG_HIZ) |=> (!pinOe[0] && !pinInBufEn[0] && !pinStateRead[0]);
   endproperty
   a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin active"); // RL1

   property p_digital_hiz;
      @(posedge clock) disable iff (!rst_n)
         (dmReg[2:0] == DM_DIGITAL_HIZ && !ibufDisReg[0]) |=> (!pinOe[0] && pinInBufEn[0]);
   endproperty
   a_digital_hiz: assert property (p_digital_hiz) else $error("digital hiz wrong"); // RL2

   property p_od_low;
      @(posedge clock) disable iff (!rst_n)
         (dmReg[2:0] == DM_OPEN_DRAIN_LOW && !bidirReg[0]) |=> (pinOe[0] == !$past(dataReg[0]));
   endproperty
   a_od_low: assert property (p_od_low) else $error("open drain low wrong"); // RL5

   property p_both_res;
      @(posedge clock) disable iff (!rst_n)
         (dmReg[2:0] == DM_RES_PULL_BOTH && !specialPin[0] && !bidirReg[0]) |=>
            (!pinOe[0] && pinPullUp[0] != pinPullDown[0]);
   endproperty
   a_both_res: assert property (p_both_res) else $error("combined pull wrong"); // RL7

   property p_event_sets;
      @(posedge clock) disable iff (!rst_n)
         evt[0] |=> (irqStatus[0] && portIrq);
   endproperty
   a_event_sets: assert property (p_event_sets) else $error("event lost"); // RL15

   property p_irq_matches;
      @(posedge clock) disable iff (!rst_n)
         portIrq == (irqStatus != ZERO_BYTE);
   endproperty
   a_irq_matches: assert property (p_irq_matches) else $error("irq not status-or"); // RL26

   property p_read_clears;
      @(posedge clock) disable iff (!rst_n)
         (statusRead && evt == ZERO_BYTE) |=> !portIrq;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("read did not clear"); // RL25

   property p_off_no_event;
      @(posedge clock) disable iff (!rst_n)
         (irqTypeReg[1:0] == IRQ_OFF) |-> !evt[0];
   endproperty
   a_off_no_event: assert property (p_off_no_event) else $error("disabled pin fired"); // RL14

   property p_defaults_load;
      @(posedge clock) disable iff (!rst_n)
         loadDefaults |=> (dmReg == $past(resetDmDefault));
   endproperty
   a_defaults_load: assert property (p_defaults_load) else $error("defaults not loaded"); // RL21

   c_rise: cover property (@(posedge clock) disable iff (!rst_n) evt[0] && pinFilt[0]);
   c_clear: cover property (@(posedge clock) disable iff (!rst_n) statusRead && portIrq);
   c_bidir: cover property (@(posedge clock) disable iff (!rst_n) bidirReg[0] && pinOe[0]);
endmodule : gpp_port
`default_nettype wire

// ==== logic/gpp_pkg.sv ====
`default_nettype none
package gpp_pkg;
   localparam int PINS = 8;
   localparam int OE_LINES = 16;
   localparam int DM_W = 3;
   localparam int OE_SEL_W = 5;
   typedef enum logic [2:0] {
      DM_ANALOG_HIZ, DM_DIGITAL_HIZ, DM_RES_PULL_UP, DM_RES_PULL_DOWN,
      DM_OPEN_DRAIN_LOW, DM_OPEN_DRAIN_HIGH, DM_STRONG, DM_RES_PULL_BOTH
   } gpp_drive_mode_t;
   typedef enum logic [1:0] {
      IRQ_OFF, IRQ_RISE, IRQ_FALL, IRQ_BOTH
   } gpp_irq_type_t;
   // Pin form: per-pin word of the most used port bits
   localparam int PF_DATA = 0;
   localparam int PF_DM_LSB = 1;
   localparam int PF_IBUF_DIS = 4;
   localparam int PF_SLOW = 5;
   localparam int PF_BIDIR = 6;
   localparam int PF_STATE = 7;
   localparam int PF_W = 8;
   localparam logic [7:0] ZERO_BYTE = 8'h00;
   localparam logic [23:0] ZERO_DM = 24'h000000;
   localparam logic [15:0] ZERO_TYPE = 16'h0000;
endpackage : gpp_pkg
`default_nettype wire

// ==== dv/gpp_pad_model.sv ====
`default_nettype none
// ****************************************
// External circuitry at the port pins
// ****************************************
module gpp_pad_model
   import gpp_pkg::*;
(
   input wire logic clock,
   input wire logic [PINS-1:0] pinOut,
   input wire logic [PINS-1:0] pinOe,
   input wire logic [PINS-1:0] pinPullUp,
   input wire logic [PINS-1:0] pinPullDown,
   input wire logic [PINS-1:0] extLevel,
   input wire logic [PINS-1:0] extEn,
   output logic [PINS-1:0] pinLevel
);
   timeunit 1ns;
   timeprecision 1ps;
   // Undriven pins wander so a stale level is never mistaken for a driven one
   logic [PINS-1:0] floatPat = 8'h55;
   always @(posedge clock) begin
      floatPat <= ~floatPat;
   end
   always_comb begin
      for (int i = 0; i < PINS; i++) begin
         if (pinOe[i]) pinLevel[i] = pinOut[i];
         else if (extEn[i]) pinLevel[i] = extLevel[i];
         else if (pinPullUp[i]) pinLevel[i] = 1'b1;
         else if (pinPullDown[i]) pinLevel[i] = 1'b0;
         else pinLevel[i] = floatPat[i];
      end
   end
endmodule : gpp_pad_model
`default_nettype wire

// ==== dv/gpp_port_test.sv ====
`default_nettype none
module gpp_port_test
   import gpp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, rst_n, lvttlSelect, portIrq, statusRead, pinWr;
   logic portWrData, portWrDm, portWrSlew, portWrIbufDis, portWrBidir, portWrIrqType;
   logic portWrCfg, lvttlIn;
   logic [7:0] pinIn, pinOut, pinOe, pinPullUp, pinPullDown, pinSlowSlew, pinInBufEn;
   logic [7:0] specialPin, regulatedOut, resetDataDefault, dataIn, slewIn, ibufDisIn;
   logic [7:0] bidirIn, pairThresholdIn, pinWrWord, pinRdWord, pinStateRead;
   logic [7:0] outputDataWrite, irqStatus, extLevel, extEn;
   logic [23:0] resetDmDefault, dmIn;
   logic [15:0] irqTypeIn, auxOe;
   logic [39:0] oeSelIn;
   logic [2:0] pinWrSel, pinRdSel;
   logic [1:0] pairThreshold0, pairThreshold1, pairThreshold2, pairThreshold3;
   int failures = 0;
   int checked = 0;
   gpp_port gpp_port_i (.clock, .rst_n, .pinIn, .pinOut, .pinOe, .pinPullUp, .pinPullDown,
      .pinSlowSlew, .pinInBufEn, .lvttlSelect, .pairThreshold0, .pairThreshold1,
      .pairThreshold2, .pairThreshold3, .specialPin, .regulatedOut, .resetDmDefault,
      .resetDataDefault, .portWrData, .dataIn, .portWrDm, .dmIn, .portWrSlew, .slewIn,
      .portWrIbufDis, .ibufDisIn, .portWrBidir, .bidirIn, .portWrIrqType, .irqTypeIn,
      .portWrCfg, .lvttlIn, .pairThresholdIn, .oeSelIn, .pinWr, .pinWrSel, .pinWrWord,
      .pinRdSel, .pinRdWord, .auxOe, .pinStateRead, .outputDataWrite, .statusRead,
      .irqStatus, .portIrq);
   gpp_pad_model gpp_pad_model_i (.clock, .pinOut, .pinOe, .pinPullUp, .pinPullDown,
      .extLevel, .extEn, .pinLevel(pinIn));
   always #2 clock = ~clock;
   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
      checked++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(negedge clock);
   endtask : tick
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
      tick(2);
   endtask : pulse
   task automatic stop_test();
      $display("checked %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : stop_test
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_reset();
      rst_n = 1'b0;
      tick(3);
      chk("rstDrive", 24'h0, {pinOe, pinPullUp, pinPullDown});
      chk("rstIbuf", 24'h0, pinInBufEn);
      rst_n = 1'b1;
      tick(4);
      chk("dfltOe", 8'hFF, pinOe);
      chk("dfltData", {8'hA5, 8'hA5}, {pinOut, outputDataWrite});
      $display("t_reset done");
   endtask : t_reset
   task automatic t_modes();
      logic [7:0] eOe, ePu, ePd;
      logic d;
      for (int m = 0; m < 8; m++) begin
         dataIn = 8'h0F;
         slewIn = 8'hFF;
         dmIn = {8{3'(m)}};
         pulse(portWrData);
         pulse(portWrSlew);
         pulse(portWrDm);
         tick(5);
         for (int i = 0; i < 8; i++) begin
            d = dataIn[i];
            eOe[i] = (m == 6) || (d ? (m == 3 || m == 5) : (m == 2 || m == 4));
            ePu[i] = d && (m == 2 || m == 7);
            ePd[i] = !d && (m == 3 || m == 7);
         end
         chk("pinOe", eOe, pinOe);
         chk("pinOut", eOe & 8'h0F, pinOe & pinOut);
         chk("pull", {ePu, ePd}, {pinPullUp, pinPullDown});
         chk("slew", (m >= 4 && m <= 6) ? 8'hFF : 8'h00, pinSlowSlew);
         chk("ibuf", m ? 8'hFF : 8'h00, pinInBufEn);
         chk("outputDataWrite", 8'h0F, outputDataWrite);
         if (m == 0 || m == 6) chk("pinState", m ? 8'h0F : 8'h00, pinStateRead);
      end
      $display("t_modes done");
   endtask : t_modes
   task automatic t_ibuf();
      dmIn = {8{3'd1}};
      extEn = 8'hFF;
      extLevel = 8'h3C;
      ibufDisIn = 8'hF0;
      pulse(portWrDm);
      pulse(portWrIbufDis);
      tick(6);
      chk("ibufEn", 8'h0F, pinInBufEn);
      chk("pinState", 8'h0C, pinStateRead);
      chk("outputDataWrite", 8'h0F, outputDataWrite);
      ibufDisIn = 8'h00;
      pulse(portWrIbufDis);
      $display("t_ibuf done");
   endtask : t_ibuf
   task automatic t_pinform();
      pinWrSel = 3'd3;
      pinWrWord = 8'h2D;
      pulse(pinWr);
      pinRdSel = 3'd3;
      tick(6);
      chk("pin3", 3'h7, {pinOe[3], pinOut[3], pinSlowSlew[3]});
      chk("pinRdWord", 8'hAD, pinRdWord);
      specialPin = 8'h08;
      regulatedOut = 8'h08;
      pinWrWord = 8'h05;
      pulse(pinWr);
      chk("regPull", 3'h1, {pinPullUp[3], pinOe[3], pinInBufEn[3]});
      regulatedOut = 8'h00;
      tick(3);
      chk("unregPull", 1'b1, pinPullUp[3]);
      // Tolerant special pin kept to open drain low, data high floats
      pinWrWord = 8'h09;
      pulse(pinWr);
      chk("tolerantOd", 2'h1, {pinOe[3], pinInBufEn[3]});
      specialPin = 8'h00;
      $display("t_pinform done");
   endtask : t_pinform
   task automatic t_bidir_cfg();
      pinWrSel = 3'd5;
      pinWrWord = 8'h4C;
      lvttlIn = 1'b1;
      pairThresholdIn = 8'hE4;
      oeSelIn = 40'h0;
      oeSelIn[29:25] = 5'd9;
      pulse(portWrCfg);
      pulse(pinWr);
      chk("cfg", 9'h1E4, {lvttlSelect, pairThreshold3, pairThreshold2,
         pairThreshold1, pairThreshold0});
      chk("bidirIn", 2'h1, {pinOe[5], pinInBufEn[5]});
      auxOe = 16'h0200;
      tick(3);
      chk("bidirOut", 1'b1, pinOe[5]);
      auxOe = 16'hFDFF;
      tick(3);
      chk("bidirOther", 1'b0, pinOe[5]);
      bidirIn = 8'h00;
      pulse(portWrBidir);
      chk("bidirOff", 1'b1, pinOe[5]);
      $display("t_bidir_cfg done");
   endtask : t_bidir_cfg
   task automatic t_irq();
      dmIn = {8{3'd1}};
      extLevel = 8'h00;
      irqTypeIn = 16'h0039;
      pulse(portWrDm);
      pulse(portWrIrqType);
      tick(8);
      pulse(statusRead);
      chk("idle", 9'h0, {portIrq, irqStatus});
      extLevel = 8'h0F;
      tick(8);
      chk("rise", 9'h105, {portIrq, irqStatus});
      pulse(statusRead);
      chk("clear", 9'h0, {portIrq, irqStatus});
      extLevel = 8'h00;
      tick(8);
      chk("fall", 9'h106, {portIrq, irqStatus});
      pulse(statusRead);
      $display("t_irq done");
   endtask : t_irq
   // ****************************************
   // Main sequence and watchdog
   // ****************************************
   initial begin
      clock = 1'b0;
      rst_n = 1'b0;
      {portWrData, portWrDm, portWrSlew, portWrIbufDis, portWrBidir} = 5'h0;
      {portWrIrqType, portWrCfg, lvttlIn, statusRead, pinWr} = 5'h0;
      {specialPin, regulatedOut, dataIn, slewIn, ibufDisIn, bidirIn} = 48'h0;
      {pairThresholdIn, pinWrWord, extLevel, extEn} = 32'h0;
      resetDmDefault = {8{3'd6}};
      resetDataDefault = 8'hA5;
      {dmIn, irqTypeIn, auxOe, oeSelIn} = 96'h0;
      {pinWrSel, pinRdSel} = 6'h0;
      t_reset();
      t_modes();
      t_ibuf();
      t_pinform();
      t_bidir_cfg();
      t_irq();
      stop_test();
   end
   initial begin
      #20us;
      failures++;
      stop_test();
   end
endmodule : gpp_port_test
`default_nettype wire
